// [hpp_port.sv]
// Notes on behaviour
// - Transfer strobe is NOT(strobe one XOR strobe two) OR chip select, active low.
// - Ready is driven only with chip select low; held low while deselected.
// - Ready shows busy at chip select fall if an earlier operation is unfinished.
// - First halfword of a data read fetches a word unless one is already prefetched; busy until loaded.
// - After second halfword of data write or incrementing read, busy until done.
// - Every other access keeps ready low.
// - Control and address register accesses never change ready.
// - Address strobe optional; tied high selects latch at transfer strobe fall.
// - Read drives data bus after strobe falls, releases it after strobe rises.
// - Read data is on the bus two clock periods before ready falls.
// - Read data holds briefly after strobe rises before the bus is released.
`timescale 1ns/100ps
module hpp_port (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Host pins
  input wire logic port_chip_select,
  input wire logic data_strobe_one,
  input wire logic data_strobe_two,
  input wire logic address_latch_strobe,
  input wire logic [1:0] register_select,
  input wire logic read_write_dir,
  input wire logic halfword_identifier,
  input wire logic [15:0] port_data_bus_in,
  output logic [15:0] port_data_bus_out,
  output logic port_data_bus_oe,
  output logic port_ready_n,
  // Control register contents
  output logic [15:0] host_ctrl,
  // Read requests to the internal address generator
  output logic rd_req_valid,
  input wire logic rd_req_ready,
  output logic [31:0] rd_req_addr,
  input wire logic rd_rsp_valid,
  input wire logic [31:0] rd_rsp_data,
  // Buffered writes to memory
  output logic wr_valid,
  input wire logic wr_ready,
  output hpp_pkg::hpp_wr_t wr_word
);

  logic [23:0] pins_sync;
  logic cs_n;
  logic ds1;
  logic ds2;
  logic as_n;
  logic [15:0] din;
  hpp_pkg::hpp_sel_t cur_sel;
  logic strobe_n;
  logic strb_fall;
  logic strb_rise;
  logic as_fall;
  hpp_pkg::hpp_sel_t acc_sel;
  logic first_data_rd;
  logic fifo_in_ready;
  hpp_pkg::hpp_wr_t fifo_in_data;

  logic strb_d_reg;
  logic strb_d_next;
  logic as_d_reg;
  logic as_d_next;
  hpp_pkg::hpp_sel_t sel_reg;
  hpp_pkg::hpp_sel_t sel_next;
  logic as_seen_reg;
  logic as_seen_next;
  hpp_pkg::hpp_state_t state_reg;
  hpp_pkg::hpp_state_t state_next;
  logic [15:0] ctrl_reg;
  logic [15:0] ctrl_next;
  logic [31:0] addr_reg;
  logic [31:0] addr_next;
  logic [31:0] data_reg;
  logic [31:0] data_next;
  logic dvalid_reg;
  logic dvalid_next;
  logic rd_wait_reg;
  logic rd_wait_next;
  logic req_sent_reg;
  logic req_sent_next;
  logic inc_reg;
  logic inc_next;
  logic [1:0] lead_reg;
  logic [1:0] lead_next;
  logic oe_reg;
  logic oe_next;
  logic [1:0] hold_reg;
  logic [1:0] hold_next;
  logic [15:0] dout_reg;
  logic [15:0] dout_next;

  // Pins come from the host's timing domain
  hpp_sync #(
    .WIDTH(24)
  ) u_sync (
    .clk(clk),
    .srst(srst),
    .async_in({port_chip_select, data_strobe_one, data_strobe_two, address_latch_strobe,
               register_select, read_write_dir, halfword_identifier, port_data_bus_in}),
    .sync_out(pins_sync)
  );

  assign cs_n = pins_sync[23];
  assign ds1 = pins_sync[22];
  assign ds2 = pins_sync[21];
  assign as_n = pins_sync[20];
  assign cur_sel = hpp_pkg::hpp_sel_t'(pins_sync[19:16]);
  assign din = pins_sync[15:0];

  assign strobe_n = ~(ds1 ^ ds2) | cs_n;
  assign strb_fall = strb_d_reg && !strobe_n;
  assign strb_rise = !strb_d_reg && strobe_n;
  assign as_fall = as_d_reg && !as_n;

  // selects from address strobe if seen, else strobe fall
  assign acc_sel = (strb_fall && !as_seen_reg) ? cur_sel : sel_reg;
  assign first_data_rd = acc_sel.rd && !acc_sel.hw && hpp_pkg::is_data(acc_sel.reg_sel);

  // busy state survives deselection and shows at next select
  // idle state with no pending read means no wait
  assign port_ready_n = !cs_n &&
    ((state_reg != hpp_pkg::ST_IDLE) || rd_wait_reg || (strb_fall && first_data_rd));

  assign rd_req_valid = (state_reg == hpp_pkg::ST_FETCH) && !req_sent_reg;
  assign rd_req_addr = addr_reg;
  assign host_ctrl = ctrl_reg;
  assign port_data_bus_out = dout_reg;
  assign port_data_bus_oe = oe_reg;
  assign fifo_in_data = '{addr: addr_reg, data: data_reg};

  always_comb begin
    strb_d_next = strobe_n;
    as_d_next = as_n;
    sel_next = sel_reg;
    as_seen_next = as_seen_reg;
    state_next = state_reg;
    ctrl_next = ctrl_reg;
    addr_next = addr_reg;
    data_next = data_reg;
    dvalid_next = dvalid_reg;
    rd_wait_next = rd_wait_reg;
    req_sent_next = req_sent_reg;
    inc_next = inc_reg;
    lead_next = lead_reg;
    oe_next = oe_reg;
    hold_next = hold_reg;

    // early latch while strobe still inactive
    if (as_fall && strobe_n) begin
      sel_next = cur_sel;
      as_seen_next = 1'b1;
    end

    if (strb_fall) begin
      sel_next = acc_sel;
      if (acc_sel.rd) begin
        oe_next = 1'b1;
        hold_next = '0;
      end
      // first halfword data read waits for a loaded word
      if (first_data_rd) begin
        rd_wait_next = 1'b1;
      end
    end

    if (strb_rise) begin
      as_seen_next = 1'b0;
      rd_wait_next = 1'b0;
      // hold read data past strobe rise
      if (oe_reg) begin
        hold_next = 2'(hpp_pkg::BUS_HOLD_CYC);
      end
      if (!sel_reg.rd) begin
        // control writes only store; address writes also mark the loaded word invalid
        case (sel_reg.reg_sel)
          hpp_pkg::SEL_CTRL: begin
            ctrl_next = din;
          end
          hpp_pkg::SEL_ADDR: begin
            if (sel_reg.hw) begin
              addr_next[31:16] = din;
            end else begin
              addr_next[15:0] = din;
            end
            dvalid_next = 1'b0;
          end
          default: begin
            if (sel_reg.hw) begin
              data_next[31:16] = din;
              // second write halfword retires the word
              state_next = hpp_pkg::ST_PUSH;
              inc_next = (sel_reg.reg_sel == hpp_pkg::SEL_DATA_INC);
            end else begin
              data_next[15:0] = din;
            end
            dvalid_next = 1'b0;
          end
        endcase
      end else if (sel_reg.hw && hpp_pkg::is_data(sel_reg.reg_sel)) begin
        dvalid_next = 1'b0;
        // incrementing read prefetches the next word
        if (sel_reg.reg_sel == hpp_pkg::SEL_DATA_INC) begin
          addr_next = addr_reg + hpp_pkg::WORD_STEP;
          state_next = hpp_pkg::ST_FETCH;
          req_sent_next = 1'b0;
        end
      end
    end

    if (hold_reg != '0) begin
      hold_next = hold_reg - 1'b1;
      if (hold_reg == 2'h1) begin
        oe_next = 1'b0;
      end
    end

    case (state_reg)
      hpp_pkg::ST_IDLE: begin
        // a read arriving during earlier work is served afterwards
        if (rd_wait_reg && !strb_rise) begin
          lead_next = '0;
          state_next = dvalid_reg ? hpp_pkg::ST_LEAD : hpp_pkg::ST_FETCH;
          req_sent_next = 1'b0;
        end
      end
      hpp_pkg::ST_FETCH: begin
        if (rd_req_valid && rd_req_ready) begin
          req_sent_next = 1'b1;
        end
        // busy until the word is loaded
        if (req_sent_reg && rd_rsp_valid) begin
          data_next = rd_rsp_data;
          dvalid_next = 1'b1;
          lead_next = '0;
          state_next = rd_wait_reg ? hpp_pkg::ST_LEAD : hpp_pkg::ST_IDLE;
        end
      end
      hpp_pkg::ST_LEAD: begin
        // bus data settles before ready falls
        lead_next = lead_reg + 1'b1;
        if (lead_reg == 2'(hpp_pkg::DATA_LEAD_P) || strb_rise) begin
          state_next = hpp_pkg::ST_IDLE;
          rd_wait_next = 1'b0;
        end
      end
      hpp_pkg::ST_PUSH: begin
        // Full buffer stretches the busy phase rather than dropping data
        if (fifo_in_ready) begin
          if (inc_reg) begin
            addr_next = addr_reg + hpp_pkg::WORD_STEP;
          end
          state_next = hpp_pkg::ST_IDLE;
        end
      end
      default: begin
        state_next = hpp_pkg::ST_IDLE;
      end
    endcase
  end

  // Read mux is registered so the bus never shows a decode glitch
  always_comb begin
    case (sel_next.reg_sel)
      hpp_pkg::SEL_CTRL: dout_next = ctrl_reg;
      hpp_pkg::SEL_ADDR: dout_next = sel_next.hw ? addr_reg[31:16] : addr_reg[15:0];
      default: dout_next = sel_next.hw ? data_reg[31:16] : data_reg[15:0];
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      strb_d_reg <= 1'b1;
      as_d_reg <= 1'b1;
      sel_reg <= '0;
      as_seen_reg <= 1'b0;
      state_reg <= hpp_pkg::ST_IDLE;
      ctrl_reg <= hpp_pkg::CTRL_RESET;
      addr_reg <= hpp_pkg::ADDR_RESET;
      data_reg <= hpp_pkg::DATA_RESET;
      dvalid_reg <= 1'b0;
      rd_wait_reg <= 1'b0;
      req_sent_reg <= 1'b0;
      inc_reg <= 1'b0;
      lead_reg <= '0;
      oe_reg <= 1'b0;
      hold_reg <= '0;
      dout_reg <= '0;
    end else begin
      strb_d_reg <= strb_d_next;
      as_d_reg <= as_d_next;
      sel_reg <= sel_next;
      as_seen_reg <= as_seen_next;
      state_reg <= state_next;
      ctrl_reg <= ctrl_next;
      addr_reg <= addr_next;
      data_reg <= data_next;
      dvalid_reg <= dvalid_next;
      rd_wait_reg <= rd_wait_next;
      req_sent_reg <= req_sent_next;
      inc_reg <= inc_next;
      lead_reg <= lead_next;
      oe_reg <= oe_next;
      hold_reg <= hold_next;
      dout_reg <= dout_next;
    end
  end

  hpp_fifo #(
    .WIDTH($bits(hpp_pkg::hpp_wr_t)),
    .DEPTH(hpp_pkg::WR_FIFO_DEPTH)
  ) u_wr_fifo (
    .clk(clk),
    .srst(srst),
    .in_valid(state_reg == hpp_pkg::ST_PUSH),
    .in_ready(fifo_in_ready),
    .in_data(fifo_in_data),
    .out_valid(wr_valid),
    .out_ready(wr_ready),
    .out_data(wr_word)
  );

endmodule : hpp_port

// [hpp_pkg.sv]
package hpp_pkg;

  // Register select encodings
  localparam logic [1:0] SEL_CTRL = 2'h0;
  localparam logic [1:0] SEL_DATA_INC = 2'h1;
  localparam logic [1:0] SEL_ADDR = 2'h2;
  localparam logic [1:0] SEL_DATA = 2'h3;

  // Reset values and address step
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [31:0] ADDR_RESET = 32'h0000_0000;
  localparam logic [31:0] DATA_RESET = 32'h0000_0000;
  localparam logic [31:0] WORD_STEP = 32'h0000_0004;

  // Timing, in CPU clock periods or ns
  localparam int CLK_PERIOD_NS = 5;
  localparam int DATA_LEAD_P = 2;
  localparam int BUS_HOLD_NS = 3;
  localparam int BUS_HOLD_CYC_RAW = (BUS_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BUS_HOLD_CYC = (BUS_HOLD_CYC_RAW < 1) ? 1 : BUS_HOLD_CYC_RAW;

  // Write buffer
  localparam int WR_FIFO_DEPTH = 32;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_FETCH = 2'h1,
    ST_LEAD = 2'h3,
    ST_PUSH = 2'h2
  } hpp_state_t;

  typedef struct packed {
    logic [1:0] reg_sel;
    logic rd;
    logic hw;
  } hpp_sel_t;

  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] data;
  } hpp_wr_t;

  function automatic logic is_data(input logic [1:0] s);
    is_data = (s == SEL_DATA_INC) || (s == SEL_DATA);
  endfunction : is_data

endpackage : hpp_pkg

// [hpp_sync.sv]
`timescale 1ns/100ps
module hpp_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Data
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] meta_next;
  logic [WIDTH-1:0] sync_reg;
  logic [WIDTH-1:0] sync_next;

  always_comb begin
    meta_next = async_in;
    sync_next = meta_reg;
  end

  // Reset value is all ones so idle strobes read inactive
  always_ff @(posedge clk) begin
    if (srst) begin
      meta_reg <= '1;
      sync_reg <= '1;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
    end
  end

  assign sync_out = sync_reg;

endmodule : hpp_sync

// [hpp_fifo.sv]
`timescale 1ns/100ps
module hpp_fifo #(
  parameter int WIDTH = 64,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wptr_reg;
  logic [AW-1:0] wptr_next;
  logic [AW-1:0] rptr_reg;
  logic [AW-1:0] rptr_next;
  logic [AW:0] count_reg;
  logic [AW:0] count_next;
  logic push;
  logic pop;

  assign in_ready = (count_reg != (AW+1)'(DEPTH));
  assign out_valid = (count_reg != '0);
  assign out_data = mem[rptr_reg];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    wptr_next = wptr_reg;
    rptr_next = rptr_reg;
    count_next = count_reg;
    if (push) begin
      wptr_next = (wptr_reg == AW'(DEPTH - 1)) ? '0 : wptr_reg + 1'b1;
    end
    if (pop) begin
      rptr_next = (rptr_reg == AW'(DEPTH - 1)) ? '0 : rptr_reg + 1'b1;
    end
    if (push && !pop) begin
      count_next = count_reg + 1'b1;
    end else if (pop && !push) begin
      count_next = count_reg - 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      wptr_reg <= '0;
      rptr_reg <= '0;
      count_reg <= '0;
    end else begin
      wptr_reg <= wptr_next;
      rptr_reg <= rptr_next;
      count_reg <= count_next;
    end
  end

  // Storage needs no reset; only written entries are ever read
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wptr_reg] <= in_data;
    end
  end

endmodule : hpp_fifo

// [hpp_monitor.sv]
`timescale 1ns/100ps
module hpp_monitor (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Host pins
  input wire logic port_chip_select,
  input wire logic data_strobe_one,
  input wire logic data_strobe_two,
  input wire logic [1:0] register_select,
  input wire logic read_write_dir,
  input wire logic halfword_identifier,
  input wire logic [15:0] port_data_bus_out,
  input wire logic port_data_bus_oe,
  input wire logic port_ready_n
);
  logic stb_n;
  hpp_pkg::hpp_sel_t sel_q;
  default clocking @(posedge clk);
  endclocking
  default disable iff (srst);
  assign stb_n = ~(data_strobe_one ^ data_strobe_two) | port_chip_select;
  // Host may change selects once the strobe has fallen
  always_ff @(posedge clk) begin
    if ($fell(stb_n)) begin
      sel_q <= {register_select, read_write_dir, halfword_identifier};
    end
  end
  a_strobe_idle: assert property (
    (port_chip_select || data_strobe_one == data_strobe_two)[*8] |-> !port_data_bus_oe)
    else $error("data bus driven without active strobe");
  a_ready_desel: assert property (
    port_chip_select[*3] |-> !port_ready_n)
    else $error("ready busy while deselected");
  a_busy_first_read: assert property (
    ($fell(stb_n) && read_write_dir && !halfword_identifier && register_select[0])
    |-> ##2 port_ready_n[*3])
    else $error("no wait on first data read halfword");
  a_busy_after_write: assert property (
    ($rose(stb_n) && !port_chip_select && sel_q.reg_sel[0] && sel_q.hw
    && (!sel_q.rd || sel_q.reg_sel == hpp_pkg::SEL_DATA_INC)) ##1 !port_chip_select[*2]
    |-> ##1 port_ready_n)
    else $error("no busy after second halfword");
  a_quiet_access: assert property (
    !port_chip_select[*4] ##0 ($fell(stb_n) && !register_select[0] && !port_ready_n)
    |-> !port_ready_n[*8])
    else $error("ready changed by register access");
  a_bus_drive: assert property (
    $fell(stb_n) |-> ##3 (port_data_bus_oe == read_write_dir))
    else $error("bus drive does not follow direction");
  a_bus_release: assert property (
    $rose(stb_n) |-> ##5 !port_data_bus_oe)
    else $error("bus not released after strobe");
  a_read_hold: assert property (
    ($rose(stb_n) && port_data_bus_oe) |-> ##2 (port_data_bus_oe && $stable(port_data_bus_out)))
    else $error("read data not held after strobe");
  a_data_lead: assert property (
    !stb_n[*3] ##0 ($fell(port_ready_n) && port_data_bus_oe)
    |-> port_data_bus_out == $past(port_data_bus_out)
    && port_data_bus_out == $past(port_data_bus_out, 2))
    else $error("read data not settled before ready");
  c_data_read: cover property ($fell(stb_n) && read_write_dir && register_select[0]);
  c_busy_end: cover property ($fell(port_ready_n));
  c_reselect: cover property ($fell(port_chip_select) ##3 port_ready_n);
endmodule : hpp_monitor

bind hpp_port hpp_monitor i_hpp_monitor (.clk, .srst, .port_chip_select, .data_strobe_one,
  .data_strobe_two, .register_select, .read_write_dir, .halfword_identifier,
  .port_data_bus_out, .port_data_bus_oe, .port_ready_n);

// [hpp_mem_model.sv]
`timescale 1ns/100ps
module hpp_mem_model (
  // Clock
  input wire logic clk,
  // Read requests
  input wire logic rd_req_valid,
  output logic rd_req_ready,
  input wire logic [31:0] rd_req_addr,
  output logic rd_rsp_valid = 1'h0,
  output logic [31:0] rd_rsp_data = 32'h0,
  // Writes
  input wire logic wr_valid,
  output logic wr_ready,
  input wire hpp_pkg::hpp_wr_t wr_word,
  // Pace
  input wire logic [7:0] rsp_delay,
  input wire logic wr_stall
);
  logic [31:0] mem [0:63];
  logic [31:0] addr_q;
  logic [7:0] wait_q;
  // Start values given here so only the clocked block drives these
  logic busy_q = 1'h0;
  initial begin
    for (int i = 0; i < 64; i++) begin
      mem[i] = {8'(i), 8'h5a, ~8'(i), 8'hc3};
    end
  end
  // One outstanding read keeps the request side stalled
  assign rd_req_ready = !busy_q;
  assign wr_ready = !wr_stall;
  always @(posedge clk) begin
    rd_rsp_valid <= 1'h0;
    rd_rsp_data <= ~rd_rsp_data;
    if (wr_valid && wr_ready) begin
      mem[wr_word.addr[7:2]] <= wr_word.data;
    end
    if (rd_req_valid && !busy_q) begin
      busy_q <= 1'h1;
      addr_q <= rd_req_addr;
      wait_q <= rsp_delay;
    end else if (busy_q && wait_q != 8'h0) begin
      wait_q <= wait_q - 8'h1;
    end else if (busy_q) begin
      busy_q <= 1'h0;
      rd_rsp_valid <= 1'h1;
      rd_rsp_data <= mem[addr_q[7:2]];
    end
  end
endmodule : hpp_mem_model

// [tb_top.sv]
`timescale 1ns/100ps
module tb_top;
  logic clk;
  logic srst;
  logic port_chip_select;
  logic data_strobe_one;
  logic data_strobe_two;
  logic address_latch_strobe;
  logic [1:0] register_select;
  logic read_write_dir;
  logic halfword_identifier;
  logic [15:0] port_data_bus_in;
  logic [15:0] port_data_bus_out;
  logic port_data_bus_oe;
  logic port_ready_n;
  logic [15:0] host_ctrl;
  logic rd_req_valid;
  logic rd_req_ready;
  logic [31:0] rd_req_addr;
  logic rd_rsp_valid;
  logic [31:0] rd_rsp_data;
  logic wr_valid;
  logic wr_ready;
  hpp_pkg::hpp_wr_t wr_word;
  logic [7:0] rsp_delay;
  logic wr_stall;
  int n_errors;
  int samples_checked;
  hpp_port i_hpp_port (.*);
  hpp_mem_model i_hpp_mem_model (.*);
  initial begin
    clk = 1'h0;
    forever #2.5 clk = ~clk;
  end
  task automatic print_verdict;
    $display("mismatches %0d, comparisons %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : print_verdict
  task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp_val
  task automatic wait_ready;
    #1;
    repeat (400) begin
      if (port_ready_n === 1'h0) return;
      @(posedge clk);
      #1;
    end
    n_errors++;
    print_verdict();
  endtask : wait_ready
  task automatic host_access(input logic [1:0] sel, input logic rd, input logic hw,
                             input logic las, input logic [15:0] wd, output logic [15:0] rdat);
    wait_ready();
    @(posedge clk);
    register_select <= sel;
    read_write_dir <= rd;
    halfword_identifier <= hw;
    port_data_bus_in <= wd;
    address_latch_strobe <= !las;
    @(posedge clk);
    data_strobe_one <= 1'h0;
    repeat (2) @(posedge clk);
    address_latch_strobe <= 1'h1;
    register_select <= ~sel;
    repeat (2) @(posedge clk);
    wait_ready();
    rdat = port_data_bus_out;
    @(posedge clk);
    data_strobe_one <= 1'h1;
    repeat (2) @(posedge clk);
    port_data_bus_in <= ~wd;
    repeat (2) @(posedge clk);
  endtask : host_access
  task automatic t_regs;
    logic [15:0] r;
    host_access(hpp_pkg::SEL_CTRL, 1'h0, 1'h0, 1'h0, 16'h5a3c, r);
    host_access(hpp_pkg::SEL_CTRL, 1'h1, 1'h1, 1'h1, 16'h0000, r);
    cmp_val({16'h0, r}, 32'h0000_5a3c);
    cmp_val({16'h0, host_ctrl}, 32'h0000_5a3c);
    host_access(hpp_pkg::SEL_ADDR, 1'h0, 1'h0, 1'h0, 16'h00a0, r);
    host_access(hpp_pkg::SEL_ADDR, 1'h0, 1'h1, 1'h1, 16'h1234, r);
    cmp_val(rd_req_addr, 32'h1234_00a0);
  endtask : t_regs
  task automatic t_read;
    logic [15:0] lo;
    logic [15:0] hi;
    host_access(hpp_pkg::SEL_DATA, 1'h1, 1'h0, 1'h1, 16'h0, lo);
    host_access(hpp_pkg::SEL_DATA, 1'h1, 1'h1, 1'h0, 16'h0, hi);
    cmp_val({hi, lo}, i_hpp_mem_model.mem[40]);
  endtask : t_read
  task automatic t_deselect;
    logic [15:0] lo;
    logic [15:0] hi;
    rsp_delay <= 8'h1e;
    host_access(hpp_pkg::SEL_DATA_INC, 1'h1, 1'h0, 1'h0, 16'h0, lo);
    host_access(hpp_pkg::SEL_DATA_INC, 1'h1, 1'h1, 1'h0, 16'h0, hi);
    cmp_val({hi, lo}, i_hpp_mem_model.mem[40]);
    port_chip_select <= 1'h1;
    data_strobe_one <= 1'h0;
    repeat (4) @(posedge clk);
    #1;
    cmp_val({31'h0, port_ready_n}, 32'h0);
    @(posedge clk);
    // Both strobes low with select is still no transfer
    port_chip_select <= 1'h0;
    data_strobe_two <= 1'h0;
    repeat (3) @(posedge clk);
    #1;
    cmp_val({31'h0, port_ready_n}, 32'h1);
    cmp_val({31'h0, port_data_bus_oe}, 32'h0);
    @(posedge clk);
    data_strobe_one <= 1'h1;
    data_strobe_two <= 1'h1;
    host_access(hpp_pkg::SEL_DATA_INC, 1'h1, 1'h0, 1'h0, 16'h0, lo);
    host_access(hpp_pkg::SEL_DATA_INC, 1'h1, 1'h1, 1'h0, 16'h0, hi);
    cmp_val({hi, lo}, i_hpp_mem_model.mem[41]);
    rsp_delay <= 8'h0;
  endtask : t_deselect
  task automatic t_fill;
    logic [15:0] r;
    wr_stall <= 1'h1;
    host_access(hpp_pkg::SEL_ADDR, 1'h0, 1'h0, 1'h0, 16'h0000, r);
    for (int j = 0; j < 33; j++) begin
      host_access(hpp_pkg::SEL_DATA_INC, 1'h0, 1'h0, 1'h0, 16'(j * 3), r);
      host_access(hpp_pkg::SEL_DATA_INC, 1'h0, 1'h1, 1'h0, 16'(j + 256), r);
    end
    // Buffer full: last word must hold the port busy
    repeat (20) @(posedge clk);
    #1;
    cmp_val({31'h0, port_ready_n}, 32'h1);
    @(posedge clk);
    wr_stall <= 1'h0;
    wait_ready();
    for (int i = 0; i < 100 && wr_valid !== 1'h0; i++) @(posedge clk);
    #1;
    cmp_val({31'h0, wr_valid}, 32'h0);
    for (int j = 0; j < 33; j++) begin
      cmp_val(i_hpp_mem_model.mem[j], {16'(j + 256), 16'(j * 3)});
    end
  endtask : t_fill
  initial begin
    srst = 1'h1;
    port_chip_select = 1'h1;
    data_strobe_one = 1'h1;
    data_strobe_two = 1'h1;
    address_latch_strobe = 1'h1;
    register_select = 2'h0;
    read_write_dir = 1'h0;
    halfword_identifier = 1'h0;
    port_data_bus_in = 16'h0;
    rsp_delay = 8'h0;
    wr_stall = 1'h0;
    n_errors = 0;
    samples_checked = 0;
    repeat (5) @(posedge clk);
    srst <= 1'h0;
    port_chip_select <= 1'h0;
    repeat (3) @(posedge clk);
    t_regs();
    t_read();
    t_deselect();
    t_fill();
    print_verdict();
  end
endmodule : tb_top
